// file: core/dac_input_and_power_control.sv
// Purpose: Sample capture pipeline and power mode control of a 10-bit converter.
// Assumes: Sample edges are one-cycle enables from logic on clk_i.
// Notes:   Control pins are synchronised; analog effects are shown as enables.
// Behaviour
// - Each accepted sample edge captures the 10-bit word.
// - Next sample edge moves latch into converter register, only once active and settled.
// - Sample edges no faster than 40 MHz.
// - Both controls low: standby, current array off.
// - Power-down high: shutdown, reference, amplifier, array off.
// - Return from shutdown settles after about 50 us.
// - Wake-up resumes the last output value.
// - Reference enable low: internal reference drives pin.
// - Reference enable high: internal reference disabled.
`timescale 1ns/1ps
module dac_input_and_power_control (
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        sample_strobe_i,
  input  wire logic [dac_ctrl_pkg::WORD_W-1:0] sample_word_i,
  input  wire logic                        power_down_select_i,
  input  wire logic                        converter_enable_i,
  input  wire logic                        reference_enable_n_i,
  output logic [dac_ctrl_pkg::WORD_W-1:0]  converter_code_o,
  output logic                             current_array_on_o,
  output logic                             control_amp_on_o,
  output logic                             internal_ref_on_o,
  output logic                             reference_pin_drive_o,
  output logic                             output_float_o,
  output logic                             output_ground_o,
  output logic                             output_settled_o,
  output logic                             rate_error_o
);
  import dac_ctrl_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    power_mode_t       mode;
    logic [11:0]       settle_cnt;
    logic [1:0]        gap_cnt;
    logic [WORD_W-1:0] input_latch;
    logic [WORD_W-1:0] conv_reg;
    logic              array_on;
    logic              amp_on;
    logic              int_ref;
    logic              ref_drive;
    logic              idle_out;
    logic              settled;
    logic              rate_err;
  } ctrl_state_t;

  ctrl_state_t r;
  ctrl_state_t next_r;
  ctrl_sync_if sync_bus ();
  power_mode_t want_mode;
  logic        accept;

  assign sync_bus.raw = {reference_enable_n_i, converter_enable_i, power_down_select_i};

  ctrl_sync u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .port    (sync_bus.sync_side)
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // Power-down wins over enable, so a stuck enable cannot block shutdown.
  always_comb begin
    next_r = r;
    if (sync_bus.synced[CTRL_PWR_DOWN]) begin
      want_mode = MODE_SHUTDOWN;
    end else if (!sync_bus.synced[CTRL_EN]) begin
      want_mode = MODE_STANDBY;
    end else begin
      want_mode = MODE_ACTIVE;
    end
    // Edges closer than the fastest sample period are dropped and flagged.
    accept          = sample_strobe_i && (r.gap_cnt == 2'h0);
    next_r.rate_err = sample_strobe_i && (r.gap_cnt != 2'h0);
    if (r.gap_cnt != 2'h0) begin
      next_r.gap_cnt = r.gap_cnt - 2'h1;
    end
    if (accept) begin
      next_r.gap_cnt     = SAMPLE_GAP_CYCLES - 2'h1;
      next_r.input_latch = sample_word_i;
      // The register only moves once the array has settled, so wake-up shows the
      // value held before power-down rather than a stale latch.
      if (r.mode == MODE_ACTIVE && r.settled) begin
        next_r.conv_reg = r.input_latch;
      end
    end
    next_r.mode = want_mode;
    if (want_mode == MODE_ACTIVE && r.mode != MODE_ACTIVE) begin
      next_r.settle_cnt = SETTLE_CYCLES;
    end else if (r.settle_cnt != 12'h000) begin
      next_r.settle_cnt = r.settle_cnt - 12'h001;
    end
    next_r.settled   = (want_mode == MODE_ACTIVE) && (r.mode == MODE_ACTIVE)
                       && (r.settle_cnt == 12'h000);
    next_r.array_on  = (want_mode == MODE_ACTIVE);
    next_r.amp_on    = (want_mode != MODE_SHUTDOWN);
    next_r.int_ref   = (want_mode != MODE_SHUTDOWN)
                       && !sync_bus.synced[CTRL_REFN];
    next_r.ref_drive = next_r.int_ref;
    next_r.idle_out  = (want_mode != MODE_ACTIVE);
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  // Reset lands in shutdown with everything off and a zero code.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '{mode: MODE_SHUTDOWN, settle_cnt: 12'h000, gap_cnt: 2'h0,
             input_latch: CODE_RESET, conv_reg: CODE_RESET, array_on: 1'b0,
             amp_on: 1'b0, int_ref: 1'b0, ref_drive: 1'b0, idle_out: 1'b1,
             settled: 1'b0, rate_err: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // Outputs come straight from the state register.
  assign converter_code_o      = r.conv_reg;
  assign current_array_on_o    = r.array_on;
  assign control_amp_on_o      = r.amp_on;
  assign internal_ref_on_o     = r.int_ref;
  assign reference_pin_drive_o = r.ref_drive;
  assign output_float_o        = r.idle_out;
  assign output_ground_o       = r.idle_out;
  assign output_settled_o      = r.settled;
  assign rate_error_o          = r.rate_err;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_latch_capture: assert property (
    sample_strobe_i && r.gap_cnt == 2'h0 |=> r.input_latch == $past(sample_word_i))
    else $error("Sample word not captured on an accepted edge.");

  a_pipeline_move: assert property (
    sample_strobe_i && r.gap_cnt == 2'h0 && r.settled && r.mode == MODE_ACTIVE
    |=> converter_code_o == $past(r.input_latch))
    else $error("Latch content did not reach the converter register.");

  a_rate_guard: assert property (
    sample_strobe_i && r.gap_cnt == 2'h0 ##1 sample_strobe_i
    |=> rate_error_o && $stable(r.input_latch))
    else $error("Too fast sample edge was not refused.");

  a_standby_array: assert property (
    r.mode == MODE_STANDBY |-> !current_array_on_o && control_amp_on_o)
    else $error("Standby does not keep amplifier on and array off.");

  a_shutdown_all: assert property (
    r.mode == MODE_SHUTDOWN |-> !current_array_on_o && !control_amp_on_o
    && !internal_ref_on_o)
    else $error("Shutdown left a block powered.");

  a_wake_settle: assert property (
    r.mode != MODE_ACTIVE ##1 r.mode == MODE_ACTIVE
    |-> r.settle_cnt == SETTLE_CYCLES && !output_settled_o ##1 !output_settled_o [*2])
    else $error("Wake-up did not start the settle wait.");

  a_hold_register: assert property (
    r.mode != MODE_ACTIVE |=> $stable(converter_code_o))
    else $error("Converter register changed while powered down.");

  a_ref_internal: assert property (
    r.mode != MODE_SHUTDOWN && !sync_bus.synced[CTRL_REFN] && !sync_bus.synced[CTRL_PWR_DOWN]
    |=> internal_ref_on_o && reference_pin_drive_o)
    else $error("Internal reference not selected.");

  a_ref_external: assert property (
    sync_bus.synced[CTRL_REFN] |=> !internal_ref_on_o && !reference_pin_drive_o)
    else $error("Internal reference still on with enable high.");

  a_output_idle: assert property (
    r.mode != MODE_ACTIVE |-> output_float_o && output_ground_o && !output_settled_o)
    else $error("Idle outputs not floated or grounded.");

  // Extra guards on refusal, holding and active mode; refusal is a path the bench
  // reaches only once, so a broken branch there cannot hide behind a lucky sequence.
  a_refuse_hold: assert property (
    sample_strobe_i && r.gap_cnt != 2'h0
    |=> rate_error_o && $stable(r.input_latch))
    else $error("Early sample edge changed the input latch.");

  a_rate_pulse: assert property (
    rate_error_o |=> !rate_error_o)
    else $error("Rate error flag stood for more than one cycle.");

  a_hold_latch: assert property (
    !sample_strobe_i |=> $stable(r.input_latch))
    else $error("Input latch changed without a sample edge.");

  a_active_array: assert property (
    r.mode == MODE_ACTIVE
    |-> current_array_on_o && control_amp_on_o && !output_float_o)
    else $error("Active mode without the current array running.");

  // While the counter runs the output must not claim to be settled, and once it
  // has run out a steady wake request must raise the flag on the next edge.
  a_settle_wait: assert property (
    r.mode == MODE_ACTIVE && r.settle_cnt != 12'h000
    |=> !output_settled_o)
    else $error("Settled flag rose before the wake-up wait ended.");

  a_settle_done: assert property (
    r.mode == MODE_ACTIVE && r.settle_cnt == 12'h000
    && !sync_bus.synced[CTRL_PWR_DOWN] && sync_bus.synced[CTRL_EN]
    |=> output_settled_o)
    else $error("Settled flag missing after the wake-up wait.");

  // During the settle wait the register keeps the value held before power-down.
  a_freeze_settle: assert property (
    r.mode == MODE_ACTIVE && !r.settled |=> $stable(converter_code_o))
    else $error("Converter register moved before the outputs settled.");

endmodule : dac_input_and_power_control

// file: core/dac_ctrl_pkg.sv
// Purpose: Shared constants and types for the converter input and power control.
// Assumes: A single 50 MHz system clock; sample edges arrive as enable pulses.
// Notes:   Times are kept in their own unit; cycle counts are derived from them.
package dac_ctrl_pkg;

  // ---------------------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------------------
  localparam int          WORD_W            = 10;
  localparam int          CTRL_W            = 3;
  localparam int          CLK_PERIOD_NS     = 20;
  localparam int          SAMPLE_PERIOD_NS  = 25;   // 40 MHz fastest sample clock.
  localparam int          SETTLE_TIME_US    = 50;
  localparam logic [11:0] SETTLE_CYCLES     =
    12'((SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0]  SAMPLE_GAP_CYCLES =
    2'((SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------------------------------------------------------------------
  // Reset values and control bit positions
  // ---------------------------------------------------------------------------
  localparam logic [WORD_W-1:0] CODE_RESET    = 10'h000;
  localparam int                CTRL_PWR_DOWN = 0;
  localparam int                CTRL_EN       = 1;
  localparam int                CTRL_REFN     = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET    = 3'h5;  // Shutdown, external reference.

  typedef enum logic [1:0] {
    MODE_ACTIVE,
    MODE_STANDBY,
    MODE_SHUTDOWN
  } power_mode_t;

endpackage : dac_ctrl_pkg

// file: core/ctrl_sync_if.sv
// Purpose: Carries the static control pins into and out of the synchroniser.
// Assumes: Raw bits come from pins outside the clock domain.
// Notes:   Only the synchronised copy may be read by block logic.
`timescale 1ns/1ps
interface ctrl_sync_if;
  import dac_ctrl_pkg::*;
  logic [CTRL_W-1:0] raw;
  logic [CTRL_W-1:0] synced;
  modport sync_side (input raw, output synced);
  modport user_side (output raw, input synced);
endinterface : ctrl_sync_if

// file: core/ctrl_sync.sv
// Purpose: Two flip-flop synchroniser for the static control pins.
// Assumes: Pins change rarely compared to the clock.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module ctrl_sync (
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  ctrl_sync_if.sync_side port
);
  import dac_ctrl_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] s1;
    logic [CTRL_W-1:0] s2;
  } sync_state_t;

  sync_state_t r;
  sync_state_t next_r;

  // Shift the raw pins through two stages.
  always_comb begin
    next_r    = r;
    next_r.s1 = port.raw;
    next_r.s2 = r.s1;
  end

  // Reset to shutdown with the external reference, the lowest power state.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= {CTRL_RESET, CTRL_RESET};
    end else begin
      r <= next_r;
    end
  end

  assign port.synced = r.s2;

endmodule : ctrl_sync

// file: verif/sample_source.sv
// Purpose: Model of the sample source that feeds one word per bench request.
// Assumes: Requests arrive from the bench on clk_i.
// Notes:   fast_i lets a scenario break the strobe spacing on purpose.
`timescale 1ns/1ps
module sample_source (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       send_i,
  input  wire logic       fast_i,
  input  wire logic [9:0] word_i,
  output logic            strobe_o,
  output logic [9:0]      sample_o
);
  // ---------------------------------------------------------------------------
  // Strobe generation
  // ---------------------------------------------------------------------------
  // Outside a strobe the bus toggles, so a design that reads stale data is caught.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strobe_o <= 1'b0;
      sample_o <= 10'h3ff;
    end else if (send_i && (fast_i || !strobe_o)) begin
      strobe_o <= 1'b1;
      sample_o <= word_i;
    end else begin
      strobe_o <= 1'b0;
      sample_o <= ~sample_o;
    end
  end
endmodule : sample_source

// file: verif/dac_input_and_power_control_tb_top.sv
// Purpose: Self-checking bench for the converter input and power control.
// Assumes: Pins pass a two-stage synchroniser; settle wait is about 2500 cycles.
// Notes:   Flags are packed as array, amp, ref, ref drive, float, ground.
`timescale 1ns/1ps
module dac_input_and_power_control_tb_top;
  import dac_ctrl_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       send = 1'b0;
  logic       fast = 1'b0;
  logic       pwr_dn = 1'b1;
  logic       en = 1'b0;
  logic       ref_n = 1'b1;
  logic [9:0] word = 10'h000;
  logic [9:0] sample;
  logic [9:0] code;
  logic       strobe, arr, amp, iref, rdrv, flt, gnd, setl, rerr;
  int         fail_count = 0;
  int         n_checks = 0;

  sample_source u_src (.clk_i(clk_i), .rst_n_i(rst_n_i), .send_i(send), .fast_i(fast),
    .word_i(word), .strobe_o(strobe), .sample_o(sample));
  dac_input_and_power_control u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .sample_strobe_i(strobe), .sample_word_i(sample), .power_down_select_i(pwr_dn),
    .converter_enable_i(en), .reference_enable_n_i(ref_n), .converter_code_o(code),
    .current_array_on_o(arr), .control_amp_on_o(amp), .internal_ref_on_o(iref),
    .reference_pin_drive_o(rdrv), .output_float_o(flt), .output_ground_o(gnd),
    .output_settled_o(setl), .rate_error_o(rerr));

  // Clock at 50 MHz.
  initial forever #10 clk_i = ~clk_i;

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  function automatic logic [9:0] flags();
    return {4'h0, arr, amp, iref, rdrv, flt, gnd};
  endfunction : flags
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // Pins need two sync edges plus one output edge, so four edges is enough.
  task automatic pins(input logic p, input logic e, input logic r);
    @(posedge clk_i);
    pwr_dn <= p;
    en <= e;
    ref_n <= r;
    repeat (4) @(posedge clk_i);
    #1;
  endtask : pins
  task automatic send_word(input logic [9:0] w);
    @(posedge clk_i);
    send <= 1'b1;
    word <= w;
    @(posedge clk_i);
    send <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask : send_word
  task automatic wait_settled();
    for (int i = 0; i < 2600 && setl !== 1'b1; i++) @(posedge clk_i);
    #1;
    chk({9'h000, setl}, 10'h001);
  endtask : wait_settled

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_wake_and_stream();
    chk(flags(), 10'h003);
    pins(1'b0, 1'b1, 1'b0);
    chk(flags(), 10'h03c);
    wait_settled();
    send_word(10'h201);
    send_word(10'h1fe);
    chk(code, 10'h201);
    send_word(10'h155);
    chk(code, 10'h1fe);
  endtask : t_wake_and_stream
  // The second of two back-to-back strobes must be dropped and flagged.
  task automatic t_rate();
    logic seen;
    @(posedge clk_i);
    fast <= 1'b1;
    send <= 1'b1;
    word <= 10'h2aa;
    @(posedge clk_i);
    word <= 10'h0d5;
    @(posedge clk_i);
    send <= 1'b0;
    fast <= 1'b0;
    @(posedge clk_i);
    #1;
    seen = rerr;
    @(posedge clk_i);
    #1;
    chk({9'h000, seen | rerr}, 10'h001);
    send_word(10'h000);
    chk(code, 10'h2aa);
  endtask : t_rate
  task automatic t_standby();
    pins(1'b0, 1'b0, 1'b0);
    chk(flags(), 10'h01f);
    send_word(10'h3c3);
    send_word(10'h0f0);
    chk(code, 10'h2aa);
    pins(1'b0, 1'b1, 1'b0);
    wait_settled();
    chk(code, 10'h2aa);
  endtask : t_standby
  task automatic t_shutdown();
    pins(1'b1, 1'b1, 1'b0);
    chk(flags(), 10'h003);
    pins(1'b0, 1'b1, 1'b1);
    chk(flags(), 10'h030);
    wait_settled();
    chk(code, 10'h2aa);
  endtask : t_shutdown

  // Main sequence; reset is held for five cycles.
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    t_wake_and_stream();
    t_rate();
    t_standby();
    t_shutdown();
    summarize();
  end

  // Watchdog well beyond three settle waits.
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    summarize();
  end
endmodule : dac_input_and_power_control_tb_top
